// *** core/mbwr_write_map.sv ***
`timescale 1ns/1ns
module mbwr_write_map import mbwr_pkg::*; #(
   parameter int STAGE_DEPTH = MBWR_STAGE_DEPTH
) (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        reset_n,
   // configuration
   input  wire logic [7:0]  network_identifier,
   // request bytes from the framer
   input  wire logic        rx_valid,
   output logic             rx_ready,
   input  wire logic [7:0]  rx_data,
   input  wire logic        rx_eof,
   // reply bytes to the framer
   output logic             tx_valid,
   input  wire logic        tx_ready,
   output logic [7:0]       tx_data,
   // parameter writes into holding space
   output logic             par_wr_valid,
   output logic [15:0]      par_wr_addr,
   output logic [15:0]      par_wr_data,
   // native address lookup
   input  wire logic        map_req,
   input  wire mbwr_blk_t   map_blk,
   input  wire logic [4:0]  map_inst,
   input  wire logic [15:0] map_offset,
   input  wire logic        map_holding,
   output logic             map_valid,
   output logic [15:0]      map_addr,
   output logic             map_ok
);
   localparam int AW = $clog2(STAGE_DEPTH);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   mbwr_state_t st_q, st_d;      // control state
   logic [8:0]  cnt_q;           // bytes taken in this frame, saturating
   logic [7:0]  id_q;            // identifier byte
   logic [7:0]  fc_q;            // function code
   logic [15:0] addr_q;          // register or starting address
   logic [15:0] word_q;          // value (single) or quantity (multi)
   logic [7:0]  bcount_q;        // byte count of a multi write
   logic [7:0]  hi_q;            // high byte of a value in flight
   logic [15:0] crc_q;           // running crc of the request
   logic [15:0] k_q;             // next staged word to fetch
   logic [15:0] pk_q;            // word index of the fetch in flight
   logic        pend_q;          // staged word arrives this cycle
   logic [2:0]  tx_idx_q;        // reply byte index
   logic [15:0] crc_tx_q;        // running crc of the reply
   logic [7:0]  tx_data_q;       // current reply byte
   logic [15:0] par_addr_q;      // parameter write address
   logic [15:0] par_data_q;      // parameter write value
   logic        par_valid_q;     // parameter write strobe
   logic [15:0] map_addr_q;      // lookup result
   logic        map_ok_q;        // lookup hit a live instance within its reservation
   logic        map_valid_q;     // lookup answer strobe
   logic        take;            // a request byte is accepted
   logic        tx_fire;         // a reply byte is accepted
   logic        single_ok, multi_ok, accept;
   logic [15:0] crc_nx;          // reply crc including current byte
   logic [8:0]  widx;            // value word slot of this byte

   mbwr_stage_if #(.AW(AW)) stg ();

   mbwr_stage_ram #(.DEPTH(STAGE_DEPTH)) u_stage (
      .mclk (mclk),
      .stg  (stg.mem)
   );

   // ----------------------------------------------------------------
   // request checks
   // ----------------------------------------------------------------
   assign rx_ready = (st_q == MBWR_ST_RX) && !rx_eof;
   assign take     = rx_valid && rx_ready;
   assign widx     = (cnt_q - 9'(MBWR_MULTI_DATA + 1)) >> 1;

   // single: fixed length, address inside the holding span
   assign single_ok = (fc_q == MBWR_FC_SINGLE) && (cnt_q == 9'(MBWR_SINGLE_LEN))
                   && (addr_q <= 16'(MBWR_HR_LAST - MBWR_HR_FIRST));
   // multi: count equals value bytes and the length agrees with it
   assign multi_ok  = (fc_q == MBWR_FC_MULTI) && (word_q != 16'h0000)
                   && (word_q <= 16'(MBWR_MAX_QTY)) && (int'(word_q) <= STAGE_DEPTH)
                   && ({8'h00, bcount_q} == {word_q[14:0], 1'b0})
                   && (cnt_q == 9'(MBWR_MULTI_DATA + MBWR_CRC_LEN) + {1'b0, bcount_q})
                   && ({1'b0, addr_q} + {1'b0, word_q} - 17'h00001
                       <= 17'(MBWR_HR_LAST - MBWR_HR_FIRST));
   // a bad checksum or another station's identifier gets no answer
   assign accept    = (crc_q == 16'h0000) && (id_q == network_identifier)
                   && (single_ok || multi_ok);

   // ----------------------------------------------------------------
   // control state
   // ----------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      case (st_q)
         MBWR_ST_RX: begin
            if (rx_eof && accept) begin
               st_d = single_ok ? MBWR_ST_TX : MBWR_ST_COMMIT;
            end
         end
         MBWR_ST_COMMIT: begin
            if (k_q == word_q - 16'h0001) begin
               st_d = MBWR_ST_TX;
            end
         end
         MBWR_ST_TX: begin
            if (tx_fire && tx_idx_q == 3'(MBWR_RESP_LAST)) begin
               st_d = MBWR_ST_RX;
            end
         end
         default: st_d = MBWR_ST_RX;
      endcase
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= MBWR_ST_RX;
      end else begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------------------------------
   // request parser; the frame end discards or keeps what was seen
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q    <= 9'h000;
         id_q     <= 8'h00;
         fc_q     <= 8'h00;
         addr_q   <= 16'h0000;
         word_q   <= 16'h0000;
         bcount_q <= 8'h00;
         hi_q     <= 8'h00;
      end else if (st_q == MBWR_ST_RX && rx_eof) begin
         cnt_q <= 9'h000;                      // fields stay for the reply
      end else if (take) begin
         if (cnt_q != 9'h1FF) begin
            cnt_q <= cnt_q + 9'h001;           // saturate on runaway frames
         end
         case (cnt_q)
            9'h000:  id_q            <= rx_data;
            9'h001:  fc_q            <= rx_data;
            9'h002:  addr_q[15:8]    <= rx_data;
            9'h003:  addr_q[7:0]     <= rx_data;
            9'h004:  word_q[15:8]    <= rx_data;
            9'h005:  word_q[7:0]     <= rx_data;
            9'h006:  bcount_q        <= rx_data;
            default: hi_q            <= rx_data;
         endcase
      end
   end

   // value words land in staging as each low byte arrives
   assign stg.wr_en   = take && (cnt_q > 9'(MBWR_MULTI_DATA)) && !cnt_q[0]
                     && (int'(widx) < STAGE_DEPTH);
   assign stg.wr_addr = widx[AW-1:0];
   assign stg.wr_data = {hi_q, rx_data};

   // running crc; a clean frame with its trailer leaves zero behind
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         crc_q <= MBWR_CRC_INIT;
      end else if (st_q == MBWR_ST_RX && rx_eof) begin
         crc_q <= MBWR_CRC_INIT;
      end else if (take) begin
         crc_q <= mbwr_crc_step(crc_q, rx_data);
      end
   end

   // ----------------------------------------------------------------
   // commit: staged values go out only after the whole frame checked
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         k_q    <= 16'h0000;
         pk_q   <= 16'h0000;
         pend_q <= 1'b0;
      end else begin
         pend_q <= stg.rd_en;
         pk_q   <= k_q;
         k_q    <= (st_q == MBWR_ST_COMMIT) ? k_q + 16'h0001 : 16'h0000;
      end
   end

   assign stg.rd_en   = (st_q == MBWR_ST_COMMIT);
   assign stg.rd_addr = k_q[AW-1:0];

   // only the holding space is written; input space has no write path
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         par_valid_q <= 1'b0;
         par_addr_q  <= 16'h0000;
         par_data_q  <= 16'h0000;
      end else if (st_q == MBWR_ST_RX && rx_eof && accept && single_ok) begin
         par_valid_q <= 1'b1;
         par_addr_q  <= addr_q;
         par_data_q  <= word_q;
      end else begin
         par_valid_q <= pend_q;
         par_addr_q  <= addr_q + pk_q;
         par_data_q  <= stg.rd_data;
      end
   end

   assign par_wr_valid = par_valid_q;
   assign par_wr_addr  = par_addr_q;
   assign par_wr_data  = par_data_q;

   // ----------------------------------------------------------------
   // reply: id, code, address, value or quantity, crc low then high
   // ----------------------------------------------------------------
   function automatic logic [7:0] resp_byte(input logic [2:0] i);
      case (i)
         3'h1:    return fc_q;
         3'h2:    return addr_q[15:8];
         3'h3:    return addr_q[7:0];
         3'h4:    return word_q[15:8];
         3'h5:    return word_q[7:0];
         default: return id_q;
      endcase
   endfunction

   assign tx_valid = (st_q == MBWR_ST_TX);
   assign tx_fire  = tx_valid && tx_ready;
   assign tx_data  = tx_data_q;
   assign crc_nx   = mbwr_crc_step(crc_tx_q, tx_data_q);

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         tx_idx_q  <= 3'h0;
         tx_data_q <= 8'h00;
         crc_tx_q  <= MBWR_CRC_INIT;
      end else if (st_q != MBWR_ST_TX && st_d == MBWR_ST_TX) begin
         tx_idx_q  <= 3'h0;
         tx_data_q <= id_q;
         crc_tx_q  <= MBWR_CRC_INIT;
      end else if (tx_fire) begin
         tx_idx_q <= tx_idx_q + 3'h1;
         if (tx_idx_q < 3'(MBWR_RESP_CRC)) begin
            crc_tx_q <= crc_nx;
         end
         if (tx_idx_q < 3'(MBWR_RESP_CRC - 1)) begin
            tx_data_q <= resp_byte(tx_idx_q + 3'h1);
         end else if (tx_idx_q == 3'(MBWR_RESP_CRC - 1)) begin
            tx_data_q <= crc_nx[7:0];
         end else begin
            tx_data_q <= crc_tx_q[15:8];
         end
      end
   end

   // ----------------------------------------------------------------
   // native address lookup: base of type and instance plus offset
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         map_valid_q <= 1'b0;
         map_addr_q  <= 16'h0000;
         map_ok_q    <= 1'b0;
      end else begin
         map_valid_q <= map_req;
         if (map_req) begin
            map_addr_q <= 16'(mbwr_base(map_blk, map_holding, map_inst) + int'(map_offset)
                              - (map_holding ? MBWR_HR_FIRST : MBWR_IR_FIRST));
            // a missing instance or offset past the reservation drives map_ok low; map_addr is still computed
            map_ok_q   <= (int'(map_inst) < mbwr_count(map_blk))
                       && (int'(map_offset) < mbwr_rsv(map_blk, map_holding));
         end
      end
   end

   assign map_valid = map_valid_q;
   assign map_addr  = map_addr_q;
   assign map_ok    = map_ok_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   logic [15:0] wr_cnt_q;        // parameter writes of the current frame
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         wr_cnt_q <= 16'h0000;
      end else if (st_q == MBWR_ST_RX && rx_eof) begin
         wr_cnt_q <= 16'h0000;
      end else if (par_valid_q) begin
         wr_cnt_q <= wr_cnt_q + 16'h0001;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   AST_SINGLE_WRITE: assert property (st_q == MBWR_ST_RX && rx_eof && accept && single_ok |=>
      par_wr_valid && par_wr_addr == $past(addr_q) && par_wr_data == $past(word_q))
      else $error("single write not forwarded");
   AST_REPLY_CODE: assert property (tx_valid && tx_idx_q == 3'h1 |-> tx_data == fc_q)
      else $error("reply code not echoed");
   AST_COUNT_MISMATCH: assert property (st_q == MBWR_ST_RX && rx_eof && fc_q == MBWR_FC_MULTI
      && {8'h00, bcount_q} != {word_q[14:0], 1'b0} |=> st_q == MBWR_ST_RX ##1 !par_wr_valid)
      else $error("bad byte count accepted");
   AST_MULTI_QTY: assert property (tx_valid && tx_idx_q == 3'h4 && fc_q == MBWR_FC_MULTI
      |-> wr_cnt_q == word_q)
      else $error("quantity differs from writes done");
   AST_HOLD_SPAN: assert property (par_wr_valid |-> par_wr_addr != 16'hFFFF)
      else $error("write beyond holding span");
   AST_FAC_INPUT: assert property (map_req && map_blk == MBWR_BLK_FACILITY && !map_holding
      |=> map_valid && map_addr == $past(map_offset))
      else $error("facility input base wrong");
   AST_GAS_HOLD: assert property (map_req && map_blk == MBWR_BLK_GAS && map_inst == 5'h01 && map_holding
      |=> map_addr == 16'(MBWR_GAS_HR_BASE + MBWR_GAS_HR_RSV - MBWR_HR_FIRST) + $past(map_offset))
      else $error("gas holding base wrong");
   AST_AI_LIMIT: assert property (map_req && map_blk == MBWR_BLK_AI && map_inst >= 5'h14
      |=> map_valid && !map_ok)
      else $error("analog input past last instance");
   AST_DROP: assert property (st_q == MBWR_ST_RX && rx_eof && (crc_q != 16'h0000
      || id_q != network_identifier) |=> !tx_valid [*2])
      else $error("bad frame answered");

   COV_SINGLE: cover property (tx_fire && tx_idx_q == 3'h7 && fc_q == MBWR_FC_SINGLE);
   COV_MULTI: cover property (tx_fire && tx_idx_q == 3'h7 && fc_q == MBWR_FC_MULTI && word_q > 16'h0002);
   COV_DROP: cover property (st_q == MBWR_ST_RX && rx_eof && !accept && cnt_q != 9'h000);
endmodule // mbwr_write_map

// *** shared/mbwr_pkg.sv ***
package mbwr_pkg;

   // ----------------------------------------------------------------
   // function codes and frame layout
   // ----------------------------------------------------------------
   localparam logic [7:0] MBWR_FC_SINGLE   = 8'h06;   // write one holding register
   localparam logic [7:0] MBWR_FC_MULTI    = 8'h10;   // write a run of holding registers
   localparam int         MBWR_SINGLE_LEN  = 8;       // id, fc, addr, value, crc
   localparam int         MBWR_MULTI_DATA  = 7;       // first value byte of a multi write
   localparam int         MBWR_CRC_LEN     = 2;       // crc trailer bytes
   localparam int         MBWR_RESP_CRC    = 6;       // reply crc position
   localparam int         MBWR_RESP_LAST   = 7;       // last reply byte index
   localparam int         MBWR_MAX_QTY     = 123;     // longest run that fits one frame
   localparam int         MBWR_STAGE_DEPTH = 128;     // staging words for a multi write
   localparam logic [15:0] MBWR_CRC_INIT   = 16'hFFFF;
   localparam logic [15:0] MBWR_CRC_POLY   = 16'hA001;

   // ----------------------------------------------------------------
   // register spaces and block map (register numbers as printed)
   // ----------------------------------------------------------------
   localparam int MBWR_IR_FIRST = 300001;
   localparam int MBWR_IR_LAST  = 365535;
   localparam int MBWR_HR_FIRST = 400001;
   localparam int MBWR_HR_LAST  = 465535;
   localparam int MBWR_FAC_IR_BASE = 300001;
   localparam int MBWR_FAC_IR_RSV  = 30;
   localparam int MBWR_FAC_HR_BASE = 404001;
   localparam int MBWR_FAC_HR_RSV  = 400;
   localparam int MBWR_FAC_MAX     = 1;
   localparam int MBWR_GAS_IR_BASE = 304901;
   localparam int MBWR_GAS_IR_RSV  = 430;
   localparam int MBWR_GAS_HR_BASE = 407511;
   localparam int MBWR_GAS_HR_RSV  = 140;
   localparam int MBWR_GAS_MAX     = 4;
   localparam int MBWR_SEQ_IR_BASE = 306621;
   localparam int MBWR_SEQ_IR_RSV  = 180;
   localparam int MBWR_SEQ_HR_BASE = 408071;
   localparam int MBWR_SEQ_HR_RSV  = 220;
   localparam int MBWR_SEQ_MAX     = 6;
   localparam int MBWR_AI_IR_BASE  = 310941;
   localparam int MBWR_AI_IR_RSV   = 70;
   localparam int MBWR_AI_HR_BASE  = 409751;
   localparam int MBWR_AI_HR_RSV   = 60;
   localparam int MBWR_AI_MAX      = 20;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      MBWR_BLK_FACILITY = 2'h0,   // facility_block
      MBWR_BLK_GAS      = 2'h1,   // gas_transmitter_block
      MBWR_BLK_SEQ      = 2'h2,   // sequencer_block
      MBWR_BLK_AI       = 2'h3    // analog_input_block
   } mbwr_blk_t;

   typedef enum logic [2:0] {
      MBWR_ST_RX     = 3'h1,      // collecting a request
      MBWR_ST_COMMIT = 3'h2,      // draining staged values
      MBWR_ST_TX     = 3'h4       // sending the reply
   } mbwr_state_t;

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   // one byte of the reflected crc-16
   function automatic logic [15:0] mbwr_crc_step(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ MBWR_CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   // base register number of one block instance
   function automatic int mbwr_base(input mbwr_blk_t b, input logic hold, input logic [4:0] inst);
      int n;
      n = int'(inst);
      case (b)
         MBWR_BLK_FACILITY: return hold ? MBWR_FAC_HR_BASE : MBWR_FAC_IR_BASE;
         MBWR_BLK_GAS:      return hold ? MBWR_GAS_HR_BASE + n * MBWR_GAS_HR_RSV
                                        : MBWR_GAS_IR_BASE + n * MBWR_GAS_IR_RSV;
         MBWR_BLK_SEQ:      return hold ? MBWR_SEQ_HR_BASE + n * MBWR_SEQ_HR_RSV
                                        : MBWR_SEQ_IR_BASE + n * MBWR_SEQ_IR_RSV;
         default:           return hold ? MBWR_AI_HR_BASE + n * MBWR_AI_HR_RSV
                                        : MBWR_AI_IR_BASE + n * MBWR_AI_IR_RSV;
      endcase
   endfunction

   // reserved registers per instance
   function automatic int mbwr_rsv(input mbwr_blk_t b, input logic hold);
      case (b)
         MBWR_BLK_FACILITY: return hold ? MBWR_FAC_HR_RSV : MBWR_FAC_IR_RSV;
         MBWR_BLK_GAS:      return hold ? MBWR_GAS_HR_RSV : MBWR_GAS_IR_RSV;
         MBWR_BLK_SEQ:      return hold ? MBWR_SEQ_HR_RSV : MBWR_SEQ_IR_RSV;
         default:           return hold ? MBWR_AI_HR_RSV  : MBWR_AI_IR_RSV;
      endcase
   endfunction

   // number of instances of a block type
   function automatic int mbwr_count(input mbwr_blk_t b);
      case (b)
         MBWR_BLK_FACILITY: return MBWR_FAC_MAX;
         MBWR_BLK_GAS:      return MBWR_GAS_MAX;
         MBWR_BLK_SEQ:      return MBWR_SEQ_MAX;
         default:           return MBWR_AI_MAX;
      endcase
   endfunction

endpackage

// *** shared/mbwr_stage_if.sv ***
`timescale 1ns/1ns
// staging memory port between the parser and its word store
interface mbwr_stage_if #(parameter int AW = 7);
   logic          wr_en;     // store one word
   logic [AW-1:0] wr_addr;   // word slot
   logic [15:0]   wr_data;   // word value
   logic          rd_en;     // fetch one word
   logic [AW-1:0] rd_addr;   // word slot
   logic [15:0]   rd_data;   // registered word, one cycle after rd_en

   modport user (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
   modport mem  (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface

// *** core/mbwr_stage_ram.sv ***
`timescale 1ns/1ns
module mbwr_stage_ram #(
   parameter int DEPTH = 128
) (
   // clock
   input wire logic      mclk,
   // word port
   mbwr_stage_if.mem     stg
);
   logic [15:0] mem_q [DEPTH];   // staged register values, no reset needed

   // ----------------------------------------------------------------
   // write and registered read
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (stg.wr_en) begin
         mem_q[stg.wr_addr] <= stg.wr_data;
      end
   end

   always_ff @(posedge mclk) begin
      if (stg.rd_en) begin
         stg.rd_data <= mem_q[stg.rd_addr];
      end
   end
endmodule // mbwr_stage_ram

// *** testbench/mbwr_master_model.sv ***
`timescale 1ns/1ns
// ----------------------------------------------------------------
// modbus master model: sends requests, sinks replies
// ----------------------------------------------------------------
module mbwr_master_model (
   // clock
   input  wire logic  mclk,
   // request bytes
   output logic       rx_valid,
   input  wire logic  rx_ready,
   output logic [7:0] rx_data,
   output logic       rx_eof,
   // reply sink
   output logic       tx_ready
);
   bit slow = 1'b0;   // random sink stalls when set
   int stalls = 0;    // request bytes that ran out of patience
   initial rx_valid = 1'b0;
   initial rx_data = 8'h00;
   initial rx_eof = 1'b0;
   initial tx_ready = 1'b1;
   // sink stalls change off the sampling edge
   always @(negedge mclk) tx_ready <= slow ? 1'($urandom_range(1)) : 1'b1;
   // reflected crc-16, init all ones
   function automatic logic [15:0] crc(input logic [7:0] f[$]);
      logic [15:0] c;
      c = 16'hFFFF;
      foreach (f[i]) begin
         c ^= {8'h00, f[i]};
         repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
      end
      return c;
   endfunction
   // one frame, crc low byte first; bad spoils the crc
   task automatic send(input logic [7:0] f[$], input bit bad);
      logic [15:0] c;
      c = crc(f) ^ {15'h0000, bad};
      f.push_back(c[7:0]);
      f.push_back(c[15:8]);
      foreach (f[i]) begin
         @(negedge mclk);
         rx_valid = 1'b1;
         rx_data = f[i];
         // ready is settled at the falling edge; bounded in case the device refuses
         for (int n = 0; n < 50 && rx_ready !== 1'b1; n++) @(negedge mclk);
         if (rx_ready !== 1'b1) stalls++;
         // the byte is taken at this rising edge
         @(posedge mclk);
      end
      @(negedge mclk);
      rx_valid = 1'b0;
      rx_data = ~rx_data;   // released line must not look valid
      rx_eof = 1'b1;
      @(negedge mclk);
      rx_eof = 1'b0;
   endtask
endmodule // mbwr_master_model

// *** testbench/mbwr_write_map_tb.sv ***
`timescale 1ns/1ns
module mbwr_write_map_tb import mbwr_pkg::*; ();
   logic        mclk, reset_n, map_req, map_holding;
   logic [7:0]  network_identifier;
   mbwr_blk_t   map_blk;
   logic [4:0]  map_inst;
   logic [15:0] map_offset;
   wire         rx_valid, rx_ready, rx_eof, tx_valid, tx_ready, par_wr_valid, map_valid, map_ok;
   wire  [7:0]  rx_data, tx_data;
   wire  [15:0] par_wr_addr, par_wr_data, map_addr;
   int          err_total, checks;
   logic [31:0] wr_q[$];   // seen writes {addr, data}
   logic [7:0]  tx_q[$];   // seen reply bytes
   int ib[4] = '{300001, 304901, 306621, 310941};
   int hb[4] = '{404001, 407511, 408071, 409751};
   int ir[4] = '{30, 430, 180, 70};
   int hr[4] = '{400, 140, 220, 60};
   int cn[4] = '{1, 4, 6, 20};
   mbwr_write_map u_dut (.mclk, .reset_n, .network_identifier, .rx_valid, .rx_ready, .rx_data, .rx_eof,
      .tx_valid, .tx_ready, .tx_data, .par_wr_valid, .par_wr_addr, .par_wr_data, .map_req, .map_blk,
      .map_inst, .map_offset, .map_holding, .map_valid, .map_addr, .map_ok);
   mbwr_master_model u_mst (.mclk, .rx_valid, .rx_ready, .rx_data, .rx_eof, .tx_ready);
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // monitor of writes and accepted reply bytes
   always @(posedge mclk) begin
      if (par_wr_valid === 1'b1) wr_q.push_back({par_wr_addr, par_wr_data});
      if (tx_valid === 1'b1 && tx_ready === 1'b1) tx_q.push_back(tx_data);
   end
   task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %0h seen %0h", w, e, g);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // queue model: writes and echo reply derived from the request
   task automatic xact(input logic [7:0] f[$], input bit good, input bit bad);
      logic [7:0] r[$];
      logic [15:0] c;
      int n, nw, j;
      wr_q.delete();
      tx_q.delete();
      u_mst.send(f, bad);
      if (good) for (n = 0; n < 400 && !(tx_q.size() == 8 && tx_valid === 1'b0); n++) @(negedge mclk);
      else repeat (30) @(negedge mclk);
      if (n == 400 || u_mst.stalls != 0) begin
         chk("reply wait", 0, 1);
         tally_and_finish();
      end
      nw = !good ? 0 : f[1] == MBWR_FC_SINGLE ? 1 : {f[4], f[5]};
      chk("write count", nw, wr_q.size());
      for (int k = 0; k < nw && k < wr_q.size(); k++) begin
         j = f[1] == MBWR_FC_SINGLE ? 4 : 7 + 2 * k;
         chk("write", {{f[2], f[3]} + 16'(k), f[j], f[j + 1]}, wr_q[k]);
      end
      r = {};
      if (good) r = f[0:5];
      c = u_mst.crc(r);
      if (good) r = {r, c[7:0], c[15:8]};
      chk("reply length", r.size(), tx_q.size());
      foreach (r[i]) chk("reply byte", r[i], tx_q[i]);
   endtask
   task automatic multi(input int q, input int bcd, input bit good, input bit bad);
      logic [7:0] f[$];
      logic [15:0] a;
      a = 16'($urandom_range(0, 65534 - q));
      f = {network_identifier, MBWR_FC_MULTI, a[15:8], a[7:0], 8'h00, 8'(q), 8'(2 * q + bcd)};
      repeat (2 * q) f.push_back(8'($urandom));
      xact(f, good, bad);
   endtask
   // one lookup: base by type, instance and space, plus offset
   task automatic look(input int b, input int i, input int off, input bit h);
      int base, ok;
      base = (h ? hb[b] : ib[b]) + i * (h ? hr[b] : ir[b]);
      ok = i < cn[b] && off < (h ? hr[b] : ir[b]);
      @(negedge mclk);
      map_req = 1'b1;
      map_blk = mbwr_blk_t'(b);
      map_inst = 5'(i);
      map_offset = 16'(off);
      map_holding = h;
      @(negedge mclk);
      map_req = 1'b0;
      chk("map valid", 1, map_valid);
      chk("map ok", ok, map_ok);
      if (ok) chk("map addr", base + off - (h ? 400001 : 300001), map_addr);
   endtask
   initial begin
      void'($urandom(32'h9EB6));
      {reset_n, map_req, map_holding, map_inst, map_offset} = '0;
      map_blk = MBWR_BLK_FACILITY;
      network_identifier = 8'($urandom_range(1, 247));
      repeat (5) @(negedge mclk);
      reset_n = 1'b1;
      for (int k = 0; k < 3; k++) xact({network_identifier, MBWR_FC_SINGLE, 8'($urandom_range(0, 254)),
         8'($urandom), 8'($urandom), 8'($urandom)}, 1, 0);
      xact({network_identifier ^ 8'h01, MBWR_FC_SINGLE, 8'h00, 8'h05, 8'h12, 8'h34}, 0, 0);
      u_mst.slow = 1'b1;
      multi(1, 0, 1, 0);
      multi(123, 0, 1, 0);
      multi(3, 0, 0, 1);
      multi(3, 2, 0, 0);
      multi(5, 0, 1, 0);
      for (int b = 0; b < 4; b++) begin
         for (int h = 0; h < 2; h++) begin
            look(b, 0, 0, h);
            look(b, cn[b] - 1, (h ? hr[b] : ir[b]) - 1, h);
            look(b, 1 % cn[b], $urandom_range(0, (h ? hr[b] : ir[b]) - 1), h);
            look(b, cn[b], 0, h);
            look(b, 0, h ? hr[b] : ir[b], h);
         end
      end
      tally_and_finish();
   end
endmodule // mbwr_write_map_tb
